// ===== emi_pkg.sv
// Constants and carrier types for the 16-bit external memory interface.
// Assumes a single 100 MHz core clock; no software-visible registers.
// Notes on behaviour
// R01 - On-chip hits finish in one cycle
// R02 - Disable input sends on-chip range external
// R03 - Disable input stable after reset release
// R04 - Byte addressed, little-endian, even word alignment
// R05 - On-chip RAM 0x8000-0x8FFF, user base 0x8024
// R06 - External space wraps; boot from 0x7FFE
// R07 - Four ordered states per external cycle
// R08 - Each state half a processor clock
// R09 - First state starts on rising clock output
// R10 - Wait states extend data setup by periods
// R11 - On-chip access: address shown, strobes idle
// R12 - Address valid first through fourth state
// R13 - Memory data valid by fourth state
// R14 - Write data driven second through fourth state
// R15 - Data bus floats except written lanes
// R16 - One active-low strobe per byte lane
// R17 - Strobes high between cycles, float under DMA
// R18 - Chip enable low on every external cycle
// R19 - Byte select latched in second state
// R20 - Byte mode: low byte then high byte
// R21 - Wait request stable during second state
// R22 - DMA request sampled per cycle timing
// R23 - Tristate bus before asserting grant
// R24 - Clock output period one microcode cycle
// R25 - Second byte cycle uses low data lines
// R26 - Grant drops before next external cycle
package emi_pkg;
   localparam logic [15:0] ONCHIP_BASE      = 16'h8000;
   localparam logic [15:0] ONCHIP_TOP       = 16'h8fff;
   localparam logic [15:0] USER_MEMORY_BASE = 16'h8024;
   localparam logic [15:0] EXT_BASE         = 16'h9000;
   localparam logic [15:0] BOOT_ADDRESS     = 16'h7ffe;
   localparam int          ONCHIP_WORDS     = 2048;
   // Processor clock output: one period is two core clocks, one half per state
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          PROC_PERIOD_NS   = 20;
   localparam int          HALF_CYCLES      = PROC_PERIOD_NS / (2 * CLK_PERIOD_NS);

   typedef struct packed
   {
      logic        write;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [1:0]  byte_en;
   } emi_req_type;

   typedef struct packed
   {
      logic        done;
      logic [15:0] rdata;
   } emi_rsp_type;
endpackage

// ===== emi_top.sv
// External memory interface with on-chip RAM and DMA hand-over.
// Assumes requests come from core logic on REF_CLK_IN; pins are async.
`timescale 1ns/1ns
`default_nettype none
module emi_top
(
   input  wire logic                 REF_CLK_IN,
   input  wire logic                 RST_IN,
   input  wire logic                 REQ_VALID_IN,
   input  wire emi_pkg::emi_req_type REQ_IN,
   output var  emi_pkg::emi_rsp_type RSP_OUT,
   output logic                      BUSY_OUT,
   input  wire logic                 ONCHIP_RAM_DISABLE_IN,
   input  wire logic                 BYTE_ACCESS_SELECT_IN,
   input  wire logic                 WAIT_REQUEST_IN,
   input  wire logic                 DMA_REQUEST_IN,
   output logic                      DMA_GRANT_OUT,
   output logic                      PROCESSOR_CLOCK_OUTPUT_OUT,
   output logic [15:0]               EXTERNAL_ADDRESS_BUS_OUT,
   output logic                      EXTERNAL_ADDRESS_BUS_OE_OUT,
   input  wire logic [15:0]          EXTERNAL_DATA_BUS_IN,
   output logic [15:0]               EXTERNAL_DATA_BUS_OUT,
   output logic [1:0]                EXTERNAL_DATA_BUS_OE_OUT,
   output logic [1:0]                BYTE_WRITE_STROBES_N_OUT,
   output logic                      BYTE_WRITE_STROBES_OE_OUT,
   output logic                      MEMORY_CHIP_ENABLE_N_OUT,
   output logic                      MEMORY_CHIP_ENABLE_OE_OUT
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0]  sync_wait;
   logic [2:0]  sync_bacc;
   logic [2:0]  sync_dreq;
   logic        wait_level;
   logic        bacc_level;
   logic        dreq_level;
   logic [15:0] din_q1;

   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         sync_wait  <= 3'h0;
         sync_bacc  <= 3'h0;
         sync_dreq  <= 3'h0;
         wait_level <= 1'b0;
         bacc_level <= 1'b0;
         dreq_level <= 1'b0;
         din_q1     <= 16'h0000;
      end
      else
      begin
         sync_wait <= {sync_wait[1:0], WAIT_REQUEST_IN};
         sync_bacc <= {sync_bacc[1:0], BYTE_ACCESS_SELECT_IN};
         sync_dreq <= {sync_dreq[1:0], DMA_REQUEST_IN};
         // A change counts only once the second and third stages agree
         if (sync_wait[2] == sync_wait[1])
            wait_level <= sync_wait[1];
         if (sync_bacc[2] == sync_bacc[1])
            bacc_level <= sync_bacc[1];
         if (sync_dreq[2] == sync_dreq[1])
            dreq_level <= sync_dreq[1];
         // Read data is sampled on every clock, chip enable or not; one stage, the word is settled
         din_q1 <= EXTERNAL_DATA_BUS_IN;
      end
   end

   // ****************************************
   // Strap capture and address decode
   // ****************************************
   logic ram_disabled;

   // R03 strap caught once after release
   logic strap_taken;
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         strap_taken  <= 1'b0;
         ram_disabled <= 1'b0;
      end
      else if (!strap_taken)
      begin
         strap_taken  <= 1'b1;
         ram_disabled <= ONCHIP_RAM_DISABLE_IN;
      end
   end

   // R05 on-chip range decode
   wire in_onchip_range = (REQ_IN.addr >= emi_pkg::ONCHIP_BASE) &&
                          (REQ_IN.addr <= emi_pkg::ONCHIP_TOP);
   // R02 disable sends range external; R06 rest goes external
   wire is_onchip       = in_onchip_range && !ram_disabled;
   // R04 word index from even address
   wire [10:0] ram_index = REQ_IN.addr[11:1];

   // ****************************************
   // On-chip RAM
   // ****************************************
   wire [15:0] ram_word;

   typedef enum {ST_IDLE, ST_T1, ST_T2, ST_WAIT, ST_T3, ST_T4, ST_DMA} emi_state_type;
   emi_state_type state;
   emi_state_type next_state;

   logic       phase;       // Processor clock phase: 0 high half, 1 low half
   logic       second;      // Second half of a byte-mode pair
   logic       byte_mode;
   logic       wait_sampled;
   emi_pkg::emi_req_type cur;

   wire accept     = REQ_VALID_IN && !BUSY_OUT && state == ST_IDLE && !dreq_level;
   wire onchip_go  = accept && is_onchip;
   wire ext_go     = accept && !is_onchip && phase;

   // R04 little-endian byte lanes merge
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_lane
         // One store per lane, so each array has a single writer
         logic [7:0] lane_mem [emi_pkg::ONCHIP_WORDS];
         assign ram_word[8*g +: 8] = lane_mem[ram_index];
         always_ff @(posedge REF_CLK_IN)
         begin
            if (onchip_go && REQ_IN.write && REQ_IN.byte_en[g])
               lane_mem[ram_index] <= REQ_IN.wdata[8*g +: 8];
         end
      end
   endgenerate

   // ****************************************
   // External cycle sequencer
   // ****************************************
   // R07 four ordered states; R08 one core clock per state
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:
         begin
            // R22 request sampled each rising edge when idle
            if (dreq_level && phase)
               next_state = ST_DMA;
            // R09 T1 starts with processor clock rising
            else if (ext_go)
               next_state = ST_T1;
         end
         ST_T1:   next_state = ST_T2;
         // R10 wait extends T2 by whole periods
         ST_T2:   next_state = wait_level ? ST_WAIT : ST_T3;
         ST_WAIT: next_state = phase ? (wait_sampled ? ST_WAIT : ST_T3) : ST_WAIT;
         ST_T3:   next_state = ST_T4;
         // R20 second byte cycle follows immediately
         ST_T4:   next_state = (byte_mode && !second) ? ST_T1 : ST_IDLE;
         // R26 grant released before next cycle
         ST_DMA:  next_state = (!dreq_level && phase) ? ST_IDLE : ST_DMA;
      endcase
   end

   wire [15:0] ext_addr = {cur.addr[15:1], second};
   wire        lane1_we = cur.write && (second ? 1'b0 : cur.byte_en[1]);
   // R20 low byte at word address first
   wire        lane0_we = cur.write && (second ? cur.byte_en[1] : cur.byte_en[0]);
   wire [15:0] out_data = second ? {8'h00, cur.wdata[15:8]} : cur.wdata;
   wire        drive    = (next_state == ST_T2 || next_state == ST_WAIT || next_state == ST_T3 ||
                           next_state == ST_T4);

   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         state        <= ST_IDLE;
         phase        <= 1'b0;
         second       <= 1'b0;
         byte_mode    <= 1'b0;
         wait_sampled <= 1'b0;
         cur          <= '0;
         BUSY_OUT     <= 1'b0;
         RSP_OUT      <= '0;
      end
      else
      begin
         // R24 clock output one period per two states
         phase <= ~phase;
         state <= next_state;
         RSP_OUT.done <= 1'b0;
         if (state == ST_WAIT && !phase)
            wait_sampled <= wait_level;
         if (state == ST_T2)
            wait_sampled <= 1'b1;
         if (accept && (is_onchip || phase))
         begin
            cur      <= REQ_IN;
            second   <= 1'b0;
            BUSY_OUT <= !is_onchip;
         end
         // R01 on-chip answer in one cycle
         if (onchip_go)
         begin
            RSP_OUT.done  <= 1'b1;
            RSP_OUT.rdata <= ram_word;
         end
         // R19 byte select latched in T2
         if (state == ST_T2 && !second)
            byte_mode <= bacc_level;
         // R13 read data sampled in T4
         if (state == ST_T4)
         begin
            if (second)
               RSP_OUT.rdata[15:8] <= din_q1[7:0];
            else
               RSP_OUT.rdata <= byte_mode ? {8'h00, din_q1[7:0]} : din_q1;
            if (byte_mode && !second)
               second <= 1'b1;
            else
            begin
               RSP_OUT.done <= 1'b1;
               BUSY_OUT     <= 1'b0;
            end
         end
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   always_ff @(posedge REF_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         PROCESSOR_CLOCK_OUTPUT_OUT  <= 1'b0;
         EXTERNAL_ADDRESS_BUS_OUT    <= 16'h0000;
         EXTERNAL_ADDRESS_BUS_OE_OUT <= 1'b1;
         EXTERNAL_DATA_BUS_OUT       <= 16'h0000;
         EXTERNAL_DATA_BUS_OE_OUT    <= 2'h0;
         BYTE_WRITE_STROBES_N_OUT    <= 2'h3;
         BYTE_WRITE_STROBES_OE_OUT   <= 1'b1;
         MEMORY_CHIP_ENABLE_N_OUT    <= 1'b1;
         MEMORY_CHIP_ENABLE_OE_OUT   <= 1'b1;
         DMA_GRANT_OUT               <= 1'b0;
      end
      else
      begin
         PROCESSOR_CLOCK_OUTPUT_OUT <= phase;
         // R23 float first, grant one cycle later
         EXTERNAL_ADDRESS_BUS_OE_OUT <= next_state != ST_DMA;
         BYTE_WRITE_STROBES_OE_OUT   <= next_state != ST_DMA;
         MEMORY_CHIP_ENABLE_OE_OUT   <= next_state != ST_DMA;
         DMA_GRANT_OUT               <= state == ST_DMA && next_state == ST_DMA;
         // R11 on-chip access shows word address
         if (onchip_go)
            EXTERNAL_ADDRESS_BUS_OUT <= {REQ_IN.addr[15:1], 1'b0};
         // R12 address held T1 through T4
         else if (next_state == ST_T1)
            EXTERNAL_ADDRESS_BUS_OUT <= (state == ST_T4) ? {cur.addr[15:1], 1'b1} :
                                        {REQ_IN.addr[15:1], 1'b0};
         // R18 chip enable low T2 to T4
         MEMORY_CHIP_ENABLE_N_OUT <= !(next_state == ST_T2 || next_state == ST_WAIT ||
                                       next_state == ST_T3 || next_state == ST_T4);
         // R16 per-lane strobes; R17 high between cycles
         BYTE_WRITE_STROBES_N_OUT <= (next_state == ST_T3) ? ~{lane1_we, lane0_we} : 2'h3;
         // R14 write data from T2 to T4
         EXTERNAL_DATA_BUS_OUT    <= out_data;
         // R15 unused lane floats; R25 second byte on low lane
         EXTERNAL_DATA_BUS_OE_OUT <= drive ? {lane1_we, lane0_we} : 2'h0;
      end
   end

endmodule
`default_nettype wire

// ===== emi_checker.sv
// Pin-level checker for the external memory interface.
// Assumes it is bound into emi_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module emi_checker
(
   input wire logic        REF_CLK_IN,
   input wire logic        RST_IN,
   input wire logic        DMA_REQUEST_IN,
   input wire logic        DMA_GRANT_OUT,
   input wire logic        PROCESSOR_CLOCK_OUTPUT_OUT,
   input wire logic [15:0] EXTERNAL_ADDRESS_BUS_OUT,
   input wire logic        EXTERNAL_ADDRESS_BUS_OE_OUT,
   input wire logic [1:0]  EXTERNAL_DATA_BUS_OE_OUT,
   input wire logic [1:0]  BYTE_WRITE_STROBES_N_OUT,
   input wire logic        BYTE_WRITE_STROBES_OE_OUT,
   input wire logic        MEMORY_CHIP_ENABLE_N_OUT,
   input wire logic        MEMORY_CHIP_ENABLE_OE_OUT
);
   // ****************
   // Properties
   // ****************
   wire logic       gnt  = DMA_GRANT_OUT;
   wire logic       ce_n = MEMORY_CHIP_ENABLE_N_OUT;
   wire logic [1:0] stb  = BYTE_WRITE_STROBES_N_OUT;
   wire logic [1:0] doe  = EXTERNAL_DATA_BUS_OE_OUT;
   wire logic       aoe  = EXTERNAL_ADDRESS_BUS_OE_OUT;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (RST_IN);
   grant_float_a: assert property (gnt |-> !aoe && doe == 2'h0
      && !BYTE_WRITE_STROBES_OE_OUT && !MEMORY_CHIP_ENABLE_OE_OUT)
      else $error("bus driven while granted");
   grant_rise_a: assert property ($rose(DMA_REQUEST_IN) |-> ##[1:40] gnt)
      else $error("grant late");
   grant_drop_a: assert property ($fell(DMA_REQUEST_IN) |-> ##[1:12] !gnt)
      else $error("grant held");
   data_write_a: assert property (doe != 2'h0 |-> !ce_n)
      else $error("data driven outside a cycle");
   lane_drive_a: assert property (!stb[0] |-> doe[0])
      else $error("strobe without data");
   high_lane_a: assert property (doe[1] |-> !EXTERNAL_ADDRESS_BUS_OUT[0])
      else $error("high lane on odd byte");
   strobe_gap_a: assert property ($fell(ce_n) |-> stb == 2'h3 && $past(aoe))
      else $error("strobe not idle at start");
   addr_hold_a: assert property (!ce_n && $past(!ce_n) |->
      $stable(EXTERNAL_ADDRESS_BUS_OUT)) else $error("address moved in cycle");
   ce_length_a: assert property ($fell(ce_n) |-> !ce_n [*2])
      else $error("cycle too short");
   clock_toggle_a: assert property ($past(!RST_IN, 2) |->
      PROCESSOR_CLOCK_OUTPUT_OUT != $past(PROCESSOR_CLOCK_OUTPUT_OUT))
      else $error("clock output stuck");
   t1_align_a: assert property ($fell(ce_n) |-> $past(PROCESSOR_CLOCK_OUTPUT_OUT) &&
      !$past(PROCESSOR_CLOCK_OUTPUT_OUT, 2)) else $error("cycle not on clock rise");
   cover property ($fell(ce_n));
   cover property (stb == 2'h0);
   cover property ($rose(gnt));
endmodule
bind emi_top emi_checker i_chk
(
   .REF_CLK_IN, .RST_IN, .DMA_REQUEST_IN, .DMA_GRANT_OUT, .PROCESSOR_CLOCK_OUTPUT_OUT,
   .EXTERNAL_ADDRESS_BUS_OUT, .EXTERNAL_ADDRESS_BUS_OE_OUT, .EXTERNAL_DATA_BUS_OE_OUT,
   .BYTE_WRITE_STROBES_N_OUT, .BYTE_WRITE_STROBES_OE_OUT, .MEMORY_CHIP_ENABLE_N_OUT,
   .MEMORY_CHIP_ENABLE_OE_OUT
);
`default_nettype wire

// ===== emi_mem_model.sv
// Behavioural static memory on the far side of the interface.
// Assumes resolved pin levels; chip enable and strobes pulled up.
`timescale 1ns/1ns
`default_nettype none
module emi_mem_model
(
   input  wire logic        clk_in,
   input  wire logic        slow_in,
   input  wire logic        byte_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] data_in,
   input  wire logic [1:0]  wr_n_in,
   input  wire logic        ce_n_in,
   output logic [15:0]      data_out,
   output logic             wait_out,
   output logic             byte_out
);
   logic [7:0]  mem [0:65535];
   logic [15:0] last;
   int          lowcnt = 0;
   // valid while selected with strobes high; otherwise the bus shows the inverse of the last data, not old data
   always_comb
      if (!ce_n_in && wr_n_in == 2'h3)
         data_out = addr_in[0] ? {~mem[addr_in], mem[addr_in]}
                               : {mem[addr_in | 16'h1], mem[addr_in]};
      else
         data_out = ~last;
   // wait only drops well after the second state
   assign wait_out = slow_in && lowcnt < 6;
   assign byte_out = byte_in;
   always @(posedge clk_in)
   begin
      if (!ce_n_in && !wr_n_in[0]) mem[addr_in] <= data_in[7:0];
      if (!ce_n_in && !wr_n_in[1] && !addr_in[0]) mem[addr_in | 16'h1] <= data_in[15:8];
      lowcnt <= ce_n_in ? 0 : lowcnt + 1;
      if (!ce_n_in) last <= data_out;
   end
endmodule
`default_nettype wire

// ===== emi_top_tb.sv
// Self-checking bench for emi_top with a static memory model.
// Assumes a 100 MHz clock and no other agent on the pins.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module emi_top_tb;
   logic clk, rst, rv, dis, dreq, gnt, pclk, aoe, soe, coe, ce_n, busy, slow, bmode;
   logic bsel, wreq;
   logic [15:0] adr, dout, mdat, q;
   logic [1:0]  doe, stb_n;
   emi_pkg::emi_req_type req;
   emi_pkg::emi_rsp_type rsp;
   int err_total = 0, total_checks = 0, falls = 0, lowlen = 0, last_n, f0, l0;
   wire logic        ce_w  = coe ? ce_n : 1'b1;
   wire logic [1:0]  stb_w = soe ? stb_n : 2'h3;
   wire logic [15:0] din   = {doe[1] ? dout[15:8] : mdat[15:8], doe[0] ? dout[7:0] : mdat[7:0]};
   emi_top i_dut (.REF_CLK_IN(clk), .RST_IN(rst), .REQ_VALID_IN(rv), .REQ_IN(req),
      .RSP_OUT(rsp), .BUSY_OUT(busy), .ONCHIP_RAM_DISABLE_IN(dis), .BYTE_ACCESS_SELECT_IN(bsel),
      .WAIT_REQUEST_IN(wreq), .DMA_REQUEST_IN(dreq), .DMA_GRANT_OUT(gnt),
      .PROCESSOR_CLOCK_OUTPUT_OUT(pclk), .EXTERNAL_ADDRESS_BUS_OUT(adr),
      .EXTERNAL_ADDRESS_BUS_OE_OUT(aoe), .EXTERNAL_DATA_BUS_IN(din), .EXTERNAL_DATA_BUS_OUT(dout),
      .EXTERNAL_DATA_BUS_OE_OUT(doe), .BYTE_WRITE_STROBES_N_OUT(stb_n),
      .BYTE_WRITE_STROBES_OE_OUT(soe), .MEMORY_CHIP_ENABLE_N_OUT(ce_n),
      .MEMORY_CHIP_ENABLE_OE_OUT(coe));
   emi_mem_model i_mem (.clk_in(clk), .slow_in(slow), .byte_in(bmode), .addr_in(adr),
      .data_in(din), .wr_n_in(stb_w), .ce_n_in(ce_w), .data_out(mdat), .wait_out(wreq),
      .byte_out(bsel));
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(negedge ce_w) falls++;
   always @(posedge clk) if (!ce_w) lowlen++;
   // ****************
   // Tasks
   // ****************
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // strap set with reset and left alone afterwards
   task automatic do_reset(input logic d);
      rst <= 1'b1;
      dis <= d;
      repeat (8) @(posedge clk);
      #1 rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic op(input logic w, input logic [15:0] a, d, input logic [1:0] be);
      req <= '{write: w, addr: a, wdata: d, byte_en: be};
      rv <= 1'b1;
      last_n = 0;
      do begin @(posedge clk); #1; last_n++; end while (rsp.done !== 1'b1 && last_n < 500);
      q = rsp.rdata;
      rv <= 1'b0;
      if (last_n >= 500) err_total++;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic t_onchip();
      slow = 1'b1;
      f0 = falls;
      op(1'b1, 16'h8024, 16'h1234, 2'h3);
      op(1'b0, 16'h8024, 16'h0, 2'h3);
      `CHK(q, 16'h1234)
      `CHK(last_n <= 2, 1'b1)
      `CHK(falls - f0, 0)
      `CHK(adr, 16'h8024)
      `CHK(busy, 1'b0)
      slow = 1'b0;
   endtask
   task automatic t_ext_word();
      f0 = falls;
      op(1'b1, 16'h9000, 16'hc3a5, 2'h3);
      `CHK(falls - f0, 1)
      `CHK({i_mem.mem[16'h9001], i_mem.mem[16'h9000]}, 16'hc3a5)
      op(1'b0, 16'h7ffe, 16'h0, 2'h3);
      `CHK(q, 16'h1234)
      op(1'b1, 16'h9020, 16'h7700, 2'h2);
      `CHK(i_mem.mem[16'h9020], 8'h11)
      `CHK(i_mem.mem[16'h9021], 8'h77)
   endtask
   task automatic t_wait();
      lowlen = 0;
      op(1'b0, 16'h9000, 16'h0, 2'h3);
      l0 = lowlen;
      slow = 1'b1;
      repeat (4) @(posedge clk);
      #1 lowlen = 0;
      op(1'b0, 16'h9000, 16'h0, 2'h3);
      slow = 1'b0;
      `CHK(q, 16'hc3a5)
      `CHK(lowlen > l0, 1'b1)
      `CHK((lowlen - l0) % 2, 0)
   endtask
   task automatic t_byte();
      bmode = 1'b1;
      repeat (4) @(posedge clk);
      #1 f0 = falls;
      op(1'b1, 16'h9010, 16'ha55a, 2'h3);
      `CHK(falls - f0, 2)
      `CHK({i_mem.mem[16'h9011], i_mem.mem[16'h9010]}, 16'ha55a)
      op(1'b0, 16'h9010, 16'h0, 2'h3);
      `CHK(q, 16'ha55a)
      bmode = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic t_dma();
      dreq <= 1'b1;
      for (int i = 0; i < 100 && gnt !== 1'b1; i++) @(posedge clk) #1;
      `CHK(gnt, 1'b1)
      `CHK({aoe, doe, soe, coe}, 5'h0)
      dreq <= 1'b0;
      for (int i = 0; i < 100 && gnt !== 1'b0; i++) @(posedge clk) #1;
      `CHK(gnt, 1'b0)
      op(1'b0, 16'h9010, 16'h0, 2'h3);
      `CHK(q, 16'ha55a)
   endtask
   task automatic t_disable();
      do_reset(1'b1);
      f0 = falls;
      op(1'b1, 16'h8000, 16'hbeef, 2'h3);
      `CHK(falls - f0, 1)
      `CHK(i_mem.mem[16'h8000], 8'hef)
   endtask
   // ****************
   // Sequence
   // ****************
   initial
   begin
      {rv, dreq, slow, bmode} = 4'h0;
      req = '0;
      i_mem.mem[16'h7ffe] = 8'h34;
      i_mem.mem[16'h7fff] = 8'h12;
      i_mem.mem[16'h9020] = 8'h11;
      do_reset(1'b0);
      t_onchip();
      t_ext_word();
      t_wait();
      t_byte();
      t_dma();
      t_disable();
      complete_run();
   end
   initial
   begin
      #300000;
      err_total++;
      complete_run();
   end
endmodule
`default_nettype wire
